// [rtl/afeoc_edge.sv]
// Edge detector for one serial port pin sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module afeoc_edge #(
   parameter logic IDLE_LEVEL = 1'b0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Pin and edges
   input wire logic pin,
   output logic rise,
   output logic fall
);
   afeoc_pkg::afeoc_edge_state_t st;
   afeoc_pkg::afeoc_edge_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.prev = pin;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st.prev <= IDLE_LEVEL;
      end else begin
         st <= next_st;
      end
   end

   // Inputs are synchronous to the clock, so one stage of history suffices.
   assign rise = pin & ~st.prev;
   assign fall = ~pin & st.prev;
endmodule : afeoc_edge
`default_nettype wire

// [rtl/afeoc_pkg.sv]
// Package with register map, field layout and frame constants of the amplifier control bank.
package afeoc_pkg;
   // ==========================================================
   // Serial frame layout
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned ADDR_BITS = 7;
   localparam int unsigned DATA_BITS = 8;
   localparam logic [4:0] CNT_HEADER = 5'h08;
   localparam logic [4:0] CNT_FRAME = 5'h10;
   localparam int unsigned RW_POS = 7;
   // ==========================================================
   // Register offsets
   localparam logic [6:0] OFF_REF_SWITCH = 7'h05;
   localparam logic [6:0] OFF_POWER_A = 7'h11;
   localparam logic [6:0] OFF_POWER_B = 7'h12;
   localparam logic [6:0] OFF_INPUT_STAGE = 7'h14;
   // ==========================================================
   // Reset values and unmapped read value
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // ==========================================================
   // Field positions
   localparam int unsigned POS_CFG_RUN_LO = 0;
   localparam int unsigned POS_CFG_RUN_HI = 2;
   localparam int unsigned POS_GP1_RUN = 3;
   localparam int unsigned POS_GP2_RUN = 4;
   localparam int unsigned POS_REF_SWITCH = 0;
   localparam int unsigned POS_FILTER_LO = 1;
   localparam int unsigned POS_FILTER_HI = 3;
   localparam int unsigned POS_MUX7_LO = 4;
   localparam int unsigned POS_MUX7_HI = 5;
   localparam int unsigned POS_CFG_STAGE_LO = 0;
   localparam int unsigned POS_CFG_STAGE_HI = 2;
   localparam int unsigned POS_GP1_STAGE = 3;
   localparam int unsigned POS_GP2_STAGE = 4;
   // ==========================================================
   // State types
   typedef struct packed {
      logic prev;
   } afeoc_edge_state_t;

   typedef struct packed {
      logic [4:0] bit_cnt;
      logic [15:0] shift_in;
      logic [7:0] shift_out;
      logic is_read;
      logic wr_stb;
      logic [6:0] wr_addr;
      logic [7:0] wr_data;
      logic miso;
      logic miso_oe;
      logic [7:0] ref_switch;
      logic [7:0] power_a;
      logic [7:0] power_b;
      logic [7:0] input_stage;
   } afeoc_state_t;
endpackage : afeoc_pkg

// [rtl/afeoc_regs.sv]
// Serial-port register bank driving the amplifier power, input stage and reference controls.
//
// Overview of operation
// - Power register A at 11h bit 3 runs general amplifier 1.
// - Power register B at 12h bit 4 runs general amplifier 2.
// - Reset clears both power registers and reference switch register to zero.
// - Reference register at 05h bit 0 connects amplifier 2 reference input.
// - Reference register also holds mux seven select and filter select fields.
// - Bits 7 and 6 of reference and input stage registers accept ones harmlessly.
// - Input stage register at 14h bit 4: zero rail-to-rail, one single-ended.
// - Input stage bit 3 selects amplifier 1 stage with same encoding.
// - Input stage register reads all zeros after reset.
// - Power register A bits 2 to 0 run configurable channels 3, 2, 1.
`timescale 1ns/1ps
`default_nettype none
module afeoc_regs (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Serial port
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // Configurable amplifier controls
   output logic [2:0] cfg_amp_run,
   output logic [2:0] cfg_amp_input_stage,
   // General-purpose amplifier controls
   output logic gp_amp1_run,
   output logic gp_amp2_run,
   output logic gp_amp1_input_stage,
   output logic gp_amp2_input_stage,
   output logic gp_amp2_ref_switch,
   // Multiplexer and filter selects
   output logic [1:0] mux_seven_select,
   output logic [2:0] filter_select_field
);
   afeoc_pkg::afeoc_state_t st;
   afeoc_pkg::afeoc_state_t next_st;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic [15:0] shifted;

   // ==========================================================
   // Pin edges
   afeoc_edge #(.IDLE_LEVEL(1'b0)) u_sclk_edge (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pin(spi_sclk),
      .rise(sclk_rise),
      .fall(sclk_fall)
   );

   afeoc_edge #(.IDLE_LEVEL(1'b1)) u_cs_edge (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pin(spi_cs_n),
      .rise(cs_rise),
      .fall(cs_fall)
   );

   assign shifted = {st.shift_in[14:0], spi_mosi};

   // ==========================================================
   // Read decode
   function automatic logic [7:0] read_reg(input afeoc_pkg::afeoc_state_t s,
                                           input logic [6:0] addr);
      logic [7:0] val;
      val = afeoc_pkg::READ_UNMAPPED;
      if (addr == afeoc_pkg::OFF_REF_SWITCH) begin
         val = s.ref_switch;
      end else if (addr == afeoc_pkg::OFF_POWER_A) begin
         val = s.power_a;
      end else if (addr == afeoc_pkg::OFF_POWER_B) begin
         val = s.power_b;
      end else if (addr == afeoc_pkg::OFF_INPUT_STAGE) begin
         val = s.input_stage;
      end
      return val;
   endfunction : read_reg

   // ==========================================================
   // Frame engine and register writes
   always_comb begin
      next_st = st;
      next_st.wr_stb = 1'b0;
      if (cs_fall) begin
         next_st.bit_cnt = '0;
         next_st.is_read = 1'b0;
         next_st.miso = 1'b0;
         next_st.miso_oe = 1'b1;
      end else if (cs_rise || spi_cs_n) begin
         // A frame cut short by deselect is dropped without any write.
         next_st.miso_oe = 1'b0;
         next_st.bit_cnt = '0;
      end else if (sclk_rise && st.bit_cnt < afeoc_pkg::CNT_FRAME) begin
         next_st.shift_in = shifted;
         next_st.bit_cnt = st.bit_cnt + 5'h01;
         if (st.bit_cnt + 5'h01 == afeoc_pkg::CNT_HEADER) begin
            next_st.is_read = shifted[afeoc_pkg::RW_POS];
            next_st.shift_out = read_reg(st, shifted[6:0]);
         end
         if (st.bit_cnt + 5'h01 == afeoc_pkg::CNT_FRAME && !st.is_read) begin
            next_st.wr_stb = 1'b1;
            next_st.wr_addr = shifted[14:8];
            next_st.wr_data = shifted[7:0];
         end
      end else if (sclk_fall && st.is_read && st.bit_cnt >= afeoc_pkg::CNT_HEADER) begin
         next_st.miso = st.shift_out[7];
         next_st.shift_out = {st.shift_out[6:0], 1'b0};
      end
      if (st.wr_stb) begin
         if (st.wr_addr == afeoc_pkg::OFF_REF_SWITCH) begin
            next_st.ref_switch = st.wr_data;
         end else if (st.wr_addr == afeoc_pkg::OFF_POWER_A) begin
            next_st.power_a = st.wr_data;
         end else if (st.wr_addr == afeoc_pkg::OFF_POWER_B) begin
            next_st.power_b = st.wr_data;
         end else if (st.wr_addr == afeoc_pkg::OFF_INPUT_STAGE) begin
            next_st.input_stage = st.wr_data;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st.bit_cnt <= '0;
         st.shift_in <= '0;
         st.shift_out <= '0;
         st.is_read <= 1'b0;
         st.wr_stb <= 1'b0;
         st.wr_addr <= '0;
         st.wr_data <= '0;
         st.miso <= 1'b0;
         st.miso_oe <= 1'b0;
         st.ref_switch <= afeoc_pkg::RST_REG;
         st.power_a <= afeoc_pkg::RST_REG;
         st.power_b <= afeoc_pkg::RST_REG;
         st.input_stage <= afeoc_pkg::RST_REG;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs: serial data from its own flops, each other output a slice of a register
   assign spi_miso = st.miso;
   assign spi_miso_oe = st.miso_oe;
   assign cfg_amp_run = st.power_a[afeoc_pkg::POS_CFG_RUN_HI:afeoc_pkg::POS_CFG_RUN_LO];
   assign gp_amp1_run = st.power_a[afeoc_pkg::POS_GP1_RUN];
   assign gp_amp2_run = st.power_b[afeoc_pkg::POS_GP2_RUN];
   assign gp_amp2_ref_switch = st.ref_switch[afeoc_pkg::POS_REF_SWITCH];
   assign mux_seven_select = st.ref_switch[afeoc_pkg::POS_MUX7_HI:afeoc_pkg::POS_MUX7_LO];
   assign filter_select_field = st.ref_switch[afeoc_pkg::POS_FILTER_HI:afeoc_pkg::POS_FILTER_LO];
   assign gp_amp2_input_stage = st.input_stage[afeoc_pkg::POS_GP2_STAGE];
   assign gp_amp1_input_stage = st.input_stage[afeoc_pkg::POS_GP1_STAGE];
   assign cfg_amp_input_stage =
      st.input_stage[afeoc_pkg::POS_CFG_STAGE_HI:afeoc_pkg::POS_CFG_STAGE_LO];

   // ==========================================================
   // Checks
   property p_gp1_run;
      @(posedge ref_clk) disable iff (!nrst)
      st.wr_stb && st.wr_addr == afeoc_pkg::OFF_POWER_A |=> gp_amp1_run == $past(st.wr_data[3]);
   endproperty
   a_gp1_run: assert property (p_gp1_run) else $error("amp1 run not taken from write");

   property p_gp2_run;
      @(posedge ref_clk) disable iff (!nrst)
      st.wr_stb && st.wr_addr == afeoc_pkg::OFF_POWER_B |=> gp_amp2_run == $past(st.wr_data[4]);
   endproperty
   a_gp2_run: assert property (p_gp2_run) else $error("amp2 run not taken from write");

   property p_reset_clear;
      @(posedge ref_clk) disable iff (!nrst)
      !$past(nrst) |-> st.power_a == 8'h00 && st.power_b == 8'h00 && st.ref_switch == 8'h00;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("register not clear at reset");

   property p_ref_switch;
      @(posedge ref_clk) disable iff (!nrst)
      st.wr_stb && st.wr_addr == afeoc_pkg::OFF_REF_SWITCH
         |=> gp_amp2_ref_switch == $past(st.wr_data[0]);
   endproperty
   a_ref_switch: assert property (p_ref_switch) else $error("reference switch wrong");

   property p_mux_filter;
      @(posedge ref_clk) disable iff (!nrst)
      st.wr_stb && st.wr_addr == afeoc_pkg::OFF_REF_SWITCH
         |=> mux_seven_select == $past(st.wr_data[5:4])
             && filter_select_field == $past(st.wr_data[3:1]);
   endproperty
   a_mux_filter: assert property (p_mux_filter) else $error("select fields wrong");

   property p_upper_bits;
      @(posedge ref_clk) disable iff (!nrst)
      st.wr_stb && st.wr_addr == afeoc_pkg::OFF_INPUT_STAGE
         |=> st.input_stage[7:6] == $past(st.wr_data[7:6])
             && cfg_amp_input_stage == $past(st.wr_data[2:0]);
   endproperty
   a_upper_bits: assert property (p_upper_bits) else $error("upper bits disturb stage");

   property p_stage2;
      @(posedge ref_clk) disable iff (!nrst)
      st.wr_stb && st.wr_addr == afeoc_pkg::OFF_INPUT_STAGE
         |=> gp_amp2_input_stage == $past(st.wr_data[4]);
   endproperty
   a_stage2: assert property (p_stage2) else $error("amp2 input stage wrong");

   property p_stage1;
      @(posedge ref_clk) disable iff (!nrst)
      st.wr_stb && st.wr_addr == afeoc_pkg::OFF_INPUT_STAGE
         |=> gp_amp1_input_stage == $past(st.wr_data[3]);
   endproperty
   a_stage1: assert property (p_stage1) else $error("amp1 input stage wrong");

   property p_stage_reset;
      @(posedge ref_clk) disable iff (!nrst)
      !$past(nrst) |-> st.input_stage == 8'h00;
   endproperty
   a_stage_reset: assert property (p_stage_reset) else $error("input stage not clear");

   property p_cfg_run;
      @(posedge ref_clk) disable iff (!nrst)
      st.wr_stb && st.wr_addr == afeoc_pkg::OFF_POWER_A |=> cfg_amp_run == $past(st.wr_data[2:0]);
   endproperty
   a_cfg_run: assert property (p_cfg_run) else $error("configurable run wrong");

   property p_hold;
      @(posedge ref_clk) disable iff (!nrst)
      !$past(st.wr_stb) |-> $stable(st.power_a) && $stable(st.power_b) && $stable(st.input_stage)
         && $stable(st.ref_switch);
   endproperty
   a_hold: assert property (p_hold) else $error("register changed without write");
endmodule : afeoc_regs
`default_nettype wire

// [testbench/afeoc_host.sv]
// Host model that drives serial frames into the amplifier control bank.
`timescale 1ns/1ps
`default_nettype none
module afeoc_host #(
   // Offsets of the topology, routing, speed and gain registers kept outside this bank.
   parameter logic [6:0] SEQ_BASE = 7'h20
) (
   // Clock
   input wire logic ref_clk,
   // Serial port
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
   end
   // ==========================================================
   // Frames
   // The low phase is twice the minimum so read data has settled before it is sampled.
   task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rdata);
      rdata = 8'h00;
      spi_cs_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      for (int i = 15; i > 15 - nbits; i--) begin
         spi_mosi <= word[i];
         repeat (4) @(posedge ref_clk);
         if (i < 8) begin
            rdata[i] = spi_miso;
         end
         spi_sclk <= 1'b1;
         repeat (2) @(posedge ref_clk);
         spi_sclk <= 1'b0;
      end
      repeat (2) @(posedge ref_clk);
      spi_cs_n <= 1'b1;
      // A released data line must not keep showing the last bit.
      spi_mosi <= ~spi_mosi;
      repeat (3) @(posedge ref_clk);
   endtask : frame

   task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      frame({1'b0, a, d}, 16, q);
   endtask : write_reg

   task automatic read_reg(input logic [6:0] a, output logic [7:0] q);
      frame({1'b1, a, 8'h00}, 16, q);
   endtask : read_reg

   task automatic start_instrument(input logic [7:0] gain_c);
      logic [7:0] seq [9];
      logic [6:0] adr [9];
      for (int i = 0; i < 9; i++) begin
         adr[i] = SEQ_BASE + 7'(i);
      end
      seq[0] = 8'haa;
      seq[1] = 8'h49;
      seq[2] = 8'hcc;
      seq[3] = 8'h13;
      adr[4] = afeoc_pkg::OFF_INPUT_STAGE;
      seq[4] = 8'h00;
      seq[5] = 8'h00;
      seq[6] = 8'h00;
      seq[7] = 8'h00;
      seq[8] = gain_c;
      for (int i = 0; i < 9; i++) begin
         write_reg(adr[i], seq[i]);
      end
      write_reg(afeoc_pkg::OFF_POWER_A, 8'h07);
   endtask : start_instrument
endmodule : afeoc_host
`default_nettype wire

// [testbench/analog_frontend_opamp_ctrl_regs_test.sv]
// Self-checking bench for the amplifier control register bank.
`timescale 1ns/1ps
`default_nettype none
module analog_frontend_opamp_ctrl_regs_test;
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] data;
      logic [7:0] back;
   } afeoc_row_t;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic cs_n, sclk, mosi, miso, miso_oe;
   logic [2:0] cfg_run, cfg_stage, filt;
   logic gp1_run, gp2_run, gp1_stage, gp2_stage, ref_sw;
   logic [1:0] mux7;
   logic [7:0] sh_rs = 8'h00, sh_pa = 8'h00, sh_pb = 8'h00, sh_is = 8'h00, q;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [6:0] regs [4] = '{7'h05, 7'h11, 7'h12, 7'h14};
   afeoc_row_t rows [10] = '{'{7'h11, 8'h08, 8'h08}, '{7'h12, 8'h10, 8'h10},
      '{7'h05, 8'h01, 8'h01}, '{7'h05, 8'hfe, 8'hfe}, '{7'h14, 8'h10, 8'h10},
      '{7'h14, 8'hc8, 8'hc8}, '{7'h11, 8'hff, 8'hff}, '{7'h12, 8'hef, 8'hef},
      '{7'h11, 8'h07, 8'h07}, '{7'h13, 8'ha5, 8'h00}};
   wire logic [15:0] got = {cfg_run, cfg_stage, gp1_run, gp2_run, gp1_stage, gp2_stage,
      ref_sw, mux7, filt};

   always #10 ref_clk = ~ref_clk;

   afeoc_host #(.SEQ_BASE(7'h20)) host_u (.ref_clk(ref_clk), .spi_cs_n(cs_n),
      .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso));
   afeoc_regs dut_u (.ref_clk(ref_clk), .nrst(nrst), .spi_cs_n(cs_n), .spi_sclk(sclk),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .cfg_amp_run(cfg_run),
      .cfg_amp_input_stage(cfg_stage), .gp_amp1_run(gp1_run), .gp_amp2_run(gp2_run),
      .gp_amp1_input_stage(gp1_stage), .gp_amp2_input_stage(gp2_stage),
      .gp_amp2_ref_switch(ref_sw), .mux_seven_select(mux7), .filter_select_field(filt));

   function automatic logic [15:0] exp_ports();
      return {sh_pa[2:0], sh_is[2:0], sh_pa[3], sh_pb[4], sh_is[3], sh_is[4], sh_rs[0],
         sh_rs[5:4], sh_rs[3:1]};
   endfunction : exp_ports

   task automatic note(input logic [6:0] a, input logic [7:0] d);
      case (a)
         afeoc_pkg::OFF_REF_SWITCH: sh_rs = d;
         afeoc_pkg::OFF_POWER_A: sh_pa = d;
         afeoc_pkg::OFF_POWER_B: sh_pb = d;
         afeoc_pkg::OFF_INPUT_STAGE: sh_is = d;
         default: ;
      endcase
   endtask : note

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk8

   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk16

   task automatic check_cleared(input string name);
      chk16(got, 16'h0000);
      foreach (regs[i]) begin
         host_u.read_reg(regs[i], q);
         chk8(q, 8'h00);
      end
      chk16({15'h0000, miso_oe}, 16'h0000);
      $display("test %s done", name);
   endtask : check_cleared

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   // A hang is cut off well above the roughly 4300 cycles the run needs.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      check_cleared("reset");
      foreach (rows[i]) begin
         host_u.write_reg(rows[i].addr, rows[i].data);
         note(rows[i].addr, rows[i].data);
         host_u.read_reg(rows[i].addr, q);
         chk8(q, rows[i].back);
         chk16(got, exp_ports());
      end
      $display("test table done");
      // A frame cut short after twelve bits must leave the register alone.
      // The data line enable must rise once the frame is selected, not only stay low.
      fork
         host_u.frame({1'b0, afeoc_pkg::OFF_POWER_B, 8'h00}, 12, q);
         begin
            repeat (5) @(posedge ref_clk);
            chk16({15'h0000, miso_oe}, 16'h0001);
         end
      join
      host_u.read_reg(afeoc_pkg::OFF_POWER_B, q);
      chk8(q, sh_pb);
      chk16(got, exp_ports());
      $display("test abort done");
      host_u.write_reg(afeoc_pkg::OFF_POWER_A, 8'h00);
      note(afeoc_pkg::OFF_POWER_A, 8'h00);
      host_u.start_instrument(8'h5a);
      note(afeoc_pkg::OFF_INPUT_STAGE, 8'h00);
      note(afeoc_pkg::OFF_POWER_A, 8'h07);
      chk16(got, exp_ports());
      host_u.read_reg(7'h20, q);
      chk8(q, 8'h00);
      $display("test instrument done");
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk16(got, 16'h0000);
      nrst <= 1'b1;
      sh_pa = 8'h00;
      sh_pb = 8'h00;
      sh_rs = 8'h00;
      sh_is = 8'h00;
      @(posedge ref_clk);
      check_cleared("second reset");
      close_out();
   end
endmodule : analog_frontend_opamp_ctrl_regs_test
`default_nettype wire
